// file: verilog/dvpt_pkg.sv
// Purpose: Shared constants and carriers of the panel video timing host.
// Assumes: Four pixels per port clock, data-valid framing only.
// Notes: Counts are in port clocks (horizontal) and lines (vertical).
package dvpt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Horizontal format, in port clocks
    localparam logic [9:0] H_ACTIVE = 10'h1e0;     // 480 active clocks
    localparam logic [9:0] H_BLANK_2D_MIN = 10'h03c; // 60
    localparam logic [9:0] H_BLANK_2D_TYP = 10'h046; // 70
    localparam logic [9:0] H_BLANK_2D_MAX = 10'h05f; // 95
    localparam logic [9:0] H_BLANK_3D = 10'h02d;   // 45, fixed
    localparam logic [9:0] H_TOTAL_3D = 10'h20d;   // 525, fixed
    localparam logic [9:0] H_TOTAL_2D_MIN = 10'h21c; // 540
    localparam logic [9:0] H_TOTAL_2D_MAX = 10'h23f; // 575
    localparam int PIX_PER_CLK = 4;                // Pixels on four ports

    ////////////////////////////////////////////////////////////////////////
    // Vertical format, in lines
    localparam logic [10:0] V_ACTIVE = 11'h438;    // 1080 active lines
    localparam logic [10:0] V_BLANK_2D_MIN = 11'h023; // 35
    localparam logic [10:0] V_BLANK_2D_TYP = 11'h02d; // 45
    localparam logic [10:0] V_BLANK_2D_MAX = 11'h037; // 55
    localparam logic [10:0] V_BLANK_3D = 11'h1bc;  // 444, fixed
    localparam logic [10:0] V_TOTAL_3D = 11'h5f4;  // 1524, fixed
    localparam logic [10:0] V_TOTAL_2D_MIN = 11'h45b; // 1115
    localparam logic [10:0] V_TOTAL_2D_MAX = 11'h46f; // 1135

    ////////////////////////////////////////////////////////////////////////
    // Port clock limits and refresh rates, kHz and Hz
    localparam int PORT_CLK_MIN_KHZ = 60000;
    localparam int PORT_CLK_TYP_KHZ = 74250;
    localparam int PORT_CLK_MAX_KHZ = 96230;
    localparam int SPREAD_DEV_PCT = 2;             // Spread deviation
    localparam int SPREAD_MOD_MAX_KHZ = 200;       // Spread modulation rate
    localparam int REFRESH_RATE_LOW_HZ = 100;
    localparam int REFRESH_RATE_HIGH_HZ = 120;

    ////////////////////////////////////////////////////////////////////////
    // Power and backlight guard time
    localparam int SYS_CLK_MHZ = 125;
    localparam int BL_GUARD_US = 1000;             // Video to backlight gap
    localparam int BL_GUARD_CYC = BL_GUARD_US * SYS_CLK_MHZ;
    localparam int GUARD_W = 20;                   // Guard counter width

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } dvpt_rgb_t;

    typedef struct packed {
        dvpt_rgb_t [PIX_PER_CLK-1:0] pix;          // Index 0 is pixel 4k+1
    } dvpt_quad_t;

    typedef struct packed {
        logic pixel_valid;        // Data-valid framing signal
        logic line_sync;          // Held low, panel ignores it
        logic frame_sync;         // Held low, panel ignores it
        logic stereo_mode_select; // Low 2D, high 3D
        dvpt_quad_t data;         // Four adjacent pixels
    } dvpt_link_t;

    typedef enum logic [2:0] {
        SEQ_OFF = 3'h0,
        SEQ_PWR_WAIT = 3'h1,
        SEQ_VID_START = 3'h2,
        SEQ_BL_WAIT = 3'h3,
        SEQ_ON = 3'h4,
        SEQ_BL_OFF = 3'h5,
        SEQ_VID_STOP = 3'h6,
        SEQ_PWR_DOWN = 3'h7
    } dvpt_seq_t;

endpackage

// file: verilog/dvpt_sync2.sv
// Purpose: Two flip-flop level synchroniser.
// Assumes: Input is a quasi-static level from another domain.
// Notes: First stage feeds the second stage only.
`timescale 1ns/1ps
module dvpt_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r; // Metastable stage

    // Two stages, reset to zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

// file: verilog/dvpt_pulse_sync.sv
// Purpose: Carries a one-cycle pulse across clock domains by a toggle.
// Assumes: Pulses are spaced by more than three destination cycles.
// Notes: Output is one destination cycle long.
`timescale 1ns/1ps
module dvpt_pulse_sync (
    input wire logic src_clk,
    input wire logic src_nrst,
    input wire logic src_pulse,
    input wire logic dst_clk,
    input wire logic dst_nrst,
    output logic dst_pulse
);

    logic tog_r;  // Source toggle
    logic [2:0] dst_r; // Two sync stages and an edge stage

    // Toggle on every source pulse
    always_ff @(posedge src_clk or negedge src_nrst)
    begin
        if (!src_nrst)
            tog_r <= 1'b0;
        else
            tog_r <= tog_r ^ src_pulse;
    end

    // Synchronise, then compare the two settled stages only
    always_ff @(posedge dst_clk or negedge dst_nrst)
    begin
        if (!dst_nrst)
            dst_r <= 3'h0;
        else
            dst_r <= {dst_r[1:0], tog_r};
    end

    assign dst_pulse = dst_r[2] ^ dst_r[1];

endmodule

// file: verilog/dvpt_host.sv
// Purpose: Host that drives a data-valid-only 1920x1080 panel link and
//          sequences panel power, video and backlight.
// Assumes: pix_clk is the port clock from a system PLL, also fed to the
//          panel; its rate sets the refresh rate.
// Notes: Control runs on clk, the stream on pix_clk.
//
// Functional notes
// [RL1] Panel frames from data-valid alone
// [RL2] Line and frame sync held low
// [RL3] Port clock 60 to 96.23 MHz
// [RL4] Spread within 2 percent, 200 kHz
// [RL5] 2D: 1080 active, 35-55 blank lines
// [RL6] 2D: 480 active, 60-95 blank clocks
// [RL7] 3D: 1524 lines, 1080 active, 444 blank
// [RL8] 3D: 525 clocks, 480 active, 45 blank
// [RL9] Refresh 100 Hz or 120 Hz only
// [RL10] Backlight only while video runs
// [RL11] Inputs low while panel supply off
// [RL12] Every signal driven once supply on
// [RL13] Stereo pin low 2D, high 3D
// [RL14] Four adjacent pixels per clock
// [RL15] Data-valid high exactly over active clocks
`timescale 1ns/1ps
module dvpt_host #(
    parameter logic [9:0] H_BLANK_2D = dvpt_pkg::H_BLANK_2D_TYP,
    parameter logic [10:0] V_BLANK_2D = dvpt_pkg::V_BLANK_2D_TYP,
    parameter int BL_GUARD_CYC = dvpt_pkg::BL_GUARD_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pix_clk,
    input wire logic video_on,
    input wire logic stereo_req,
    input wire logic supply_good,
    output logic panel_pwr_en,
    output logic backlight_en,
    output logic video_running,
    output logic frame_pulse,
    output logic pix_req,
    input wire dvpt_pkg::dvpt_quad_t pix_in,
    output dvpt_pkg::dvpt_link_t link_o
);

    ////////////////////////////////////////////////////////////////////////
    // Control domain state
    typedef struct packed {
        dvpt_pkg::dvpt_seq_t seq;      // Power sequencer state
        logic [dvpt_pkg::GUARD_W-1:0] cnt; // Guard countdown
        logic pwr;                     // Panel supply enable
        logic vid_en;                  // Video enable toward pix domain
        logic bl;                      // Backlight enable
    } dvpt_ctl_t;

    // Stream domain state
    typedef struct packed {
        logic run;                     // Frames being sent
        logic mode3d;                  // Format of the current frame
        logic [9:0] hcnt;              // Clock within line
        logic [10:0] vcnt;             // Line within frame
        logic fstart;                  // Frame start pulse
        dvpt_pkg::dvpt_link_t link;    // Registered pins
    } dvpt_pix_t;

    dvpt_ctl_t ctl_r;
    dvpt_ctl_t ctl_nxt;
    dvpt_pix_t px_r;
    dvpt_pix_t px_nxt;

    logic prst_n;      // Reset released on pix_clk
    logic supply_s;    // Supply good, synchronised
    logic vid_run_s;   // Stream running, seen on clk
    logic vid_en_p;    // Video enable, seen on pix_clk
    logic stereo_p;    // Stereo request, seen on pix_clk
    logic [9:0] h_total;
    logic [10:0] v_total;
    logic active;      // Current count is inside the picture
    logic line_end;
    logic frame_end;

    localparam logic [dvpt_pkg::GUARD_W-1:0] GUARD_LOAD =
        dvpt_pkg::GUARD_W'(BL_GUARD_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Crossings
    // Reset release for the stream domain
    dvpt_sync2 #(.W(1)) u_prst (.clk(pix_clk), .nrst(nrst), .d(1'b1),
        .q(prst_n));

    // Supply pin into the control domain
    dvpt_sync2 #(.W(1)) u_supply (.clk(clk), .nrst(nrst), .d(supply_good),
        .q(supply_s));

    // Running level back to the control domain
    dvpt_sync2 #(.W(1)) u_run (.clk(clk), .nrst(nrst), .d(px_r.run),
        .q(vid_run_s));

    // Enable and stereo request into the stream domain
    dvpt_sync2 #(.W(2)) u_ctl (.clk(pix_clk), .nrst(prst_n),
        .d({ctl_r.vid_en, stereo_req}), .q({vid_en_p, stereo_p}));

    // Frame start event to the control domain
    dvpt_pulse_sync u_frame (.src_clk(pix_clk), .src_nrst(prst_n),
        .src_pulse(px_r.fstart), .dst_clk(clk), .dst_nrst(nrst),
        .dst_pulse(frame_pulse));

    ////////////////////////////////////////////////////////////////////////
    // Control sequencer: supply, then video, then backlight; reverse on stop

    // Next state of the sequencer
    always_comb
    begin
        ctl_nxt = ctl_r;
        if (ctl_r.cnt != '0)
            ctl_nxt.cnt = ctl_r.cnt - 1'b1;
        case (ctl_r.seq)
            dvpt_pkg::SEQ_OFF:
            begin
                // Video request starts the bring-up
                if (video_on)
                begin
                    ctl_nxt.pwr = 1'b1;
                    ctl_nxt.seq = dvpt_pkg::SEQ_PWR_WAIT;
                end
            end
            dvpt_pkg::SEQ_PWR_WAIT:
            begin
                // No stream before the supply is good
                if (!video_on)
                begin
                    ctl_nxt.pwr = 1'b0; // RL11
                    ctl_nxt.seq = dvpt_pkg::SEQ_OFF;
                end
                else if (supply_s)
                begin
                    ctl_nxt.vid_en = 1'b1; // RL11
                    ctl_nxt.seq = dvpt_pkg::SEQ_VID_START;
                end
            end
            dvpt_pkg::SEQ_VID_START:
            begin
                // Stream confirmed running before the guard starts
                if (vid_run_s)
                begin
                    ctl_nxt.cnt = GUARD_LOAD;
                    ctl_nxt.seq = dvpt_pkg::SEQ_BL_WAIT;
                end
            end
            dvpt_pkg::SEQ_BL_WAIT:
            begin
                // Light only after video has settled
                if (ctl_r.cnt == '0)
                begin
                    ctl_nxt.bl = 1'b1; // RL10
                    ctl_nxt.seq = dvpt_pkg::SEQ_ON;
                end
            end
            dvpt_pkg::SEQ_ON:
            begin
                // Stop request darkens the backlight first
                if (!video_on)
                begin
                    ctl_nxt.bl = 1'b0; // RL10
                    ctl_nxt.cnt = GUARD_LOAD;
                    ctl_nxt.seq = dvpt_pkg::SEQ_BL_OFF;
                end
            end
            dvpt_pkg::SEQ_BL_OFF:
            begin
                // Video stops only after the guard
                if (ctl_r.cnt == '0)
                begin
                    ctl_nxt.vid_en = 1'b0;
                    ctl_nxt.seq = dvpt_pkg::SEQ_VID_STOP;
                end
            end
            dvpt_pkg::SEQ_VID_STOP:
            begin
                // Stream finishes its frame, then the pins idle low
                if (!vid_run_s)
                begin
                    ctl_nxt.cnt = GUARD_LOAD;
                    ctl_nxt.seq = dvpt_pkg::SEQ_PWR_DOWN;
                end
            end
            dvpt_pkg::SEQ_PWR_DOWN:
            begin
                // Supply removed last
                if (ctl_r.cnt == '0)
                begin
                    ctl_nxt.pwr = 1'b0;
                    ctl_nxt.seq = dvpt_pkg::SEQ_OFF;
                end
            end
            default:
            begin
                ctl_nxt = '0;
            end
        endcase
    end

    // Control registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ctl_r <= '0;
        else
            ctl_r <= ctl_nxt;
    end

    assign panel_pwr_en = ctl_r.pwr;
    assign backlight_en = ctl_r.bl;
    assign video_running = vid_run_s;

    ////////////////////////////////////////////////////////////////////////
    // Stream timing on the port clock; the port clock rate is the
    // system's job and sets 100 Hz or 120 Hz (RL3, RL4, RL9)

    // Totals for the frame in flight
    assign h_total = px_r.mode3d ? dvpt_pkg::H_TOTAL_3D // RL8
                     : dvpt_pkg::H_ACTIVE + H_BLANK_2D; // RL6
    assign v_total = px_r.mode3d ? dvpt_pkg::V_TOTAL_3D // RL7
                     : dvpt_pkg::V_ACTIVE + V_BLANK_2D; // RL5

    assign active = (px_r.hcnt < dvpt_pkg::H_ACTIVE) &&
                    (px_r.vcnt < dvpt_pkg::V_ACTIVE);
    assign line_end = (px_r.hcnt == h_total - 10'h001);
    assign frame_end = line_end && (px_r.vcnt == v_total - 11'h001);

    // Data is wanted in the cycle the count is active
    assign pix_req = px_r.run && active; // RL15

    // Next state of the stream
    always_comb
    begin
        px_nxt = px_r;
        px_nxt.fstart = 1'b0;
        if (!px_r.run)
        begin
            // Idle: counters parked, start only on a frame boundary
            px_nxt.hcnt = '0;
            px_nxt.vcnt = '0;
            px_nxt.mode3d = 1'b0;
            if (vid_en_p)
            begin
                px_nxt.run = 1'b1;
                px_nxt.mode3d = stereo_p; // RL13
                px_nxt.fstart = 1'b1;
            end
        end
        else if (frame_end)
        begin
            // Whole frames only; format may change here alone
            px_nxt.hcnt = '0;
            px_nxt.vcnt = '0;
            if (vid_en_p)
            begin
                px_nxt.mode3d = stereo_p; // RL13
                px_nxt.fstart = 1'b1;
            end
            else
            begin
                px_nxt.run = 1'b0;
                px_nxt.mode3d = 1'b0;
            end
        end
        else if (line_end)
        begin
            px_nxt.hcnt = '0;
            px_nxt.vcnt = px_r.vcnt + 11'h001;
        end
        else
        begin
            px_nxt.hcnt = px_r.hcnt + 10'h001;
        end

        // Registered pins; everything low while stopped
        px_nxt.link.pixel_valid = pix_req; // RL1
        px_nxt.link.line_sync = 1'b0; // RL2
        px_nxt.link.frame_sync = 1'b0; // RL2
        px_nxt.link.stereo_mode_select = px_nxt.mode3d; // RL13
        // Pixel 4k+1 rides port one, 4k+4 port four
        px_nxt.link.data = pix_req ? pix_in : '0; // RL14
    end

    // Stream registers; pins are driven from reset onward
    always_ff @(posedge pix_clk or negedge prst_n)
    begin
        if (!prst_n)
            px_r <= '0;
        else
            px_r <= px_nxt;
    end

    assign link_o = px_r.link; // RL11 RL12

    ////////////////////////////////////////////////////////////////////////
    // Checks, stream domain

    logic [9:0] de_len_r;    // Length of the current valid run
    logic [10:0] de_lines_r; // Valid lines seen in this frame
    logic [9:0] hlen_r;      // Clocks since the current line began

    // Helper counters read only by the checks
    always_ff @(posedge pix_clk or negedge prst_n)
    begin
        if (!prst_n)
        begin
            de_len_r <= '0;
            de_lines_r <= '0;
            hlen_r <= '0;
        end
        else
        begin
            de_len_r <= link_o.pixel_valid ? de_len_r + 10'h001 : 10'h000;
            hlen_r <= (px_r.hcnt == 10'h000) ? 10'h001 : hlen_r + 10'h001;
            if (px_r.fstart)
                de_lines_r <= '0;
            else if ($fell(link_o.pixel_valid))
                de_lines_r <= de_lines_r + 11'h001;
        end
    end

    sequence s_line_wrap;
        line_end && px_r.run && !frame_end;
    endsequence

    sequence s_next_line;
        px_r.hcnt == 10'h000 ##0 px_r.vcnt == $past(px_r.vcnt) + 11'h001;
    endsequence

    AST_SYNC_LOW: assert property (@(posedge pix_clk) // RL2
        disable iff (!prst_n) !link_o.line_sync && !link_o.frame_sync)
        else $error("sync pin not low");
    AST_DE_WIDTH: assert property (@(posedge pix_clk) // RL15
        disable iff (!prst_n) $fell(link_o.pixel_valid) |-> de_len_r == 10'h1e0)
        else $error("data-valid run not 480 clocks");
    AST_LINE_WRAP: assert property (@(posedge pix_clk) // RL6
        disable iff (!prst_n) s_line_wrap |=> s_next_line)
        else $error("line did not wrap at total");
    AST_VBLANK: assert property (@(posedge pix_clk) // RL5
        disable iff (!prst_n)
        (px_r.vcnt >= dvpt_pkg::V_ACTIVE) |=> !link_o.pixel_valid)
        else $error("data-valid in vertical blank");
    AST_LINES: assert property (@(posedge pix_clk) // RL7
        disable iff (!prst_n)
        (px_r.fstart && px_r.vcnt == 11'h000 && $past(px_r.run))
        |-> de_lines_r == 11'h438)
        else $error("frame did not carry 1080 lines");
    // Line length counted in helper logic; no check at the start of the first 3D line
    AST_3D_TOTAL: assert property (@(posedge pix_clk) // RL8
        disable iff (!prst_n) (px_r.run && px_r.mode3d && px_r.hcnt == 10'h000
        && $past(px_r.run) && $past(px_r.mode3d)) |-> hlen_r == 10'h20d)
        else $error("3D line not 525 clocks");
    AST_MODE_HOLD: assert property (@(posedge pix_clk) // RL13
        disable iff (!prst_n) $changed(link_o.stereo_mode_select) |->
        px_r.fstart || !px_r.run)
        else $error("stereo pin changed within a frame");
    AST_DATA_IDLE: assert property (@(posedge pix_clk) // RL14
        disable iff (!prst_n) !link_o.pixel_valid |-> link_o.data == '0)
        else $error("data not zero outside valid");

    ////////////////////////////////////////////////////////////////////////
    // Checks, control domain
    AST_BL_RUN: assert property (@(posedge clk) // RL10
        disable iff (!nrst) backlight_en |-> vid_run_s && ctl_r.vid_en)
        else $error("backlight on without video");
    AST_BL_FIRST_OFF: assert property (@(posedge clk) // RL10
        disable iff (!nrst)
        $fell(ctl_r.vid_en) |-> !backlight_en && !$past(backlight_en))
        else $error("video stopped before backlight off");
    AST_PWR_FIRST: assert property (@(posedge clk) // RL11
        disable iff (!nrst) ctl_r.vid_en |-> panel_pwr_en)
        else $error("video enabled without supply");

endmodule

// file: testbench/dvpt_panel_model.sv
// Purpose: Panel-side model that measures the framing it receives.
// Assumes: Link is sampled on the rising port clock edge.
// Notes: A finished line is reported when the next one starts.
`timescale 1ns/1ps
module dvpt_panel_model (
    input wire logic pix_clk,
    input wire logic nrst,
    input wire dvpt_pkg::dvpt_link_t link_i,
    output logic line_evt,
    output logic [11:0] act_len,
    output logic [11:0] blank_len,
    output logic [11:0] last_pix,
    output logic mode_3d,
    output logic sync_seen
);
    logic [11:0] act_run; // Valid clocks in this line
    logic [11:0] blank_run; // Low clocks since the last valid run
    logic [11:0] col; // Highest pixel number taken so far
    logic cur_mode; // Format read at the start of this line

    ////////////////////////////////////////////////////////////////////////
    // Framing from data-valid only; sync pins are watched, never used
    always @(posedge pix_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            line_evt <= 1'b0;
            act_run <= 12'h000;
            blank_run <= 12'h001; // So the first rise opens a line
            col <= 12'h000;
            cur_mode <= 1'b0;
            sync_seen <= 1'b0;
        end
        else
        begin
            line_evt <= 1'b0;
            if (link_i.line_sync || link_i.frame_sync)
                sync_seen <= 1'b1;
            if (link_i.pixel_valid)
            begin
                if (blank_run != 12'h000)
                begin
                    // Rise after a low spell closes the previous line
                    line_evt <= (act_run != 12'h000);
                    act_len <= act_run;
                    blank_len <= blank_run;
                    last_pix <= col;
                    mode_3d <= cur_mode;
                    cur_mode <= link_i.stereo_mode_select;
                    act_run <= 12'h001;
                    col <= 12'h004;
                    blank_run <= 12'h000;
                end
                else
                begin
                    act_run <= act_run + 12'h001;
                    col <= col + 12'h004;
                end
            end
            else
                blank_run <= blank_run + 12'h001;
        end
    end
endmodule

// file: testbench/tb_dvpt_host.sv
// Purpose: Self-checking bench of the panel video timing host.
// Assumes: Short backlight guard and the minimum 2D line blank.
// Notes: A full frame is far too long; a few lines per mode are checked.
`timescale 1ns/1ps
module tb_dvpt_host;
    localparam int BLG = 20; // Shortened guard, keeps the run short
    localparam logic [9:0] HB2 = 10'h03c; // Minimum 2D blank
    logic clk = 1'b0;
    logic pix_clk = 1'b0;
    logic nrst = 1'b0;
    logic video_on = 1'b0;
    logic stereo_req = 1'b0;
    logic supply_good = 1'b0;
    logic panel_pwr_en, backlight_en, video_running, frame_pulse, pix_req;
    dvpt_pkg::dvpt_quad_t pix_in = '0;
    dvpt_pkg::dvpt_link_t link_o;
    logic line_evt, mode_3d, sync_seen;
    logic [11:0] act_len, blank_len, last_pix;
    logic req_n; // Accept strobe seen mid-cycle
    dvpt_pkg::dvpt_quad_t cur_n; // Pixels on offer mid-cycle
    dvpt_pkg::dvpt_quad_t exp_q[$]; // Accepted, not yet on the link
    int fail_count = 0;
    int total_checks = 0;
    int frames = 0; // Frame starts seen since reset

    ////////////////////////////////////////////////////////////////////////
    // Clocks: port clock rises only between control clock rising edges
    always #4 clk = ~clk;
    always #16 pix_clk = ~pix_clk;

    dvpt_host #(.H_BLANK_2D(HB2), .BL_GUARD_CYC(BLG)) dvpt_host_i (
        .clk(clk), .nrst(nrst), .pix_clk(pix_clk), .video_on(video_on),
        .stereo_req(stereo_req), .supply_good(supply_good),
        .panel_pwr_en(panel_pwr_en), .backlight_en(backlight_en),
        .video_running(video_running), .frame_pulse(frame_pulse),
        .pix_req(pix_req), .pix_in(pix_in), .link_o(link_o));

    dvpt_panel_model dvpt_panel_model_i (
        .pix_clk(pix_clk), .nrst(nrst), .link_i(link_o),
        .line_evt(line_evt), .act_len(act_len), .blank_len(blank_len),
        .last_pix(last_pix), .mode_3d(mode_3d), .sync_seen(sync_seen));

    ////////////////////////////////////////////////////////////////////////
    // Reporting and comparison
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic miss(input string m);
        $display("mismatch at %0t: %s", $time, m);
        fail_count++;
    endtask

    task automatic chk1(input logic a, input logic e, input string m);
        total_checks++;
        if (a !== e)
            miss(m);
    endtask

    task automatic chkn(input logic [11:0] a, input logic [11:0] e,
                        input string m);
        total_checks++;
        if (a !== e)
            miss(m);
    endtask

    task automatic chkd(input dvpt_pkg::dvpt_quad_t a,
                        input dvpt_pkg::dvpt_quad_t e, input string m);
        total_checks++;
        if (a !== e)
            miss(m);
    endtask

    function automatic logic sel(input int w);
        case (w)
            0: return panel_pwr_en;
            1: return video_running;
            default: return backlight_en;
        endcase
    endfunction

    // Bounded wait on a control output, n counts the cycles taken
    task automatic wait_for(input int w, input logic v, input int lim,
                            output int n);
        n = 0;
        while (sel(w) !== v)
        begin
            if (n == lim)
            begin
                miss("timeout");
                close_out();
            end
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic do_reset(input int len);
        @(posedge clk);
        nrst <= 1'b0;
        video_on <= 1'b0;
        supply_good <= 1'b0;
        // Mid-run resets are held longer to span three port clock edges
        repeat (len) @(posedge clk);
        nrst <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Sequencing and backlight order seen every control cycle
    // Skipped in reset: the pins settle only at the first port clock edge
    always @(posedge clk)
    begin
        if (nrst !== 1'b1)
            frames = 0;
        else
        begin
            if (frame_pulse === 1'b1)
                frames++;
            if (backlight_en === 1'b1)
                chk1(video_running, 1'b1, "backlight without video");
            if (panel_pwr_en !== 1'b1)
                chk1(link_o === '0, 1'b1, "link driven unpowered");
            else
                chk1((^link_o) !== 1'bx, 1'b1, "link floating");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel stream: random pixels, queued when taken, compared when shown
    always @(negedge pix_clk)
    begin
        req_n = pix_req;
        cur_n = pix_in;
    end

    task automatic run_mode(input logic s);
        int n;
        int lines;
        @(posedge clk);
        stereo_req <= s;
        video_on <= 1'b1;
        wait_for(0, 1'b1, 4, n);
        repeat (5) @(posedge clk);
        supply_good <= 1'b1;
        wait_for(1, 1'b1, 200, n);
        chk1(backlight_en, 1'b0, "backlight before video");
        wait_for(2, 1'b1, BLG + 10, n);
        chk1(n >= BLG, 1'b1, "backlight guard short");
        lines = 0;
        n = 0;
        while (lines < 2)
        begin
            @(posedge pix_clk);
            n++;
            if (n > 3000)
            begin
                miss("no line seen");
                close_out();
            end
            if (line_evt === 1'b1)
            begin
                lines++;
                chkn(act_len, {2'h0, dvpt_pkg::H_ACTIVE}, "active");
                chkn(blank_len, s ? {2'h0, dvpt_pkg::H_BLANK_3D}
                     : {2'h0, HB2}, "blank");
                chkn(last_pix, 12'h780, "pixels per line");
                chk1(mode_3d, s, "format pin");
            end
        end
        chk1(sync_seen, 1'b0, "sync pins moved");
        chk1(frames == 1, 1'b1, "frame start count");
        @(posedge clk);
        video_on <= 1'b0;
        wait_for(2, 1'b0, BLG + 10, n);
        chk1(video_running, 1'b1, "video stopped first");
        $display("test %s done", s ? "3d" : "2d");
    endtask

    initial
    begin
        void'($urandom(15401));
        fork
            forever
            begin
                @(posedge pix_clk);
                if (!nrst)
                    exp_q.delete();
                else if (link_o.pixel_valid === 1'b1)
                begin
                    if (exp_q.size() == 0)
                        miss("pixel never taken");
                    else
                        chkd(link_o.data, exp_q.pop_front(), "data");
                end
                if (nrst && req_n === 1'b1)
                    exp_q.push_back(cur_n);
                pix_in <= {$urandom, $urandom, $urandom};
            end
        join_none
        do_reset(10);
        run_mode(1'b0);
        do_reset(14);
        run_mode(1'b1);
        close_out();
    end
endmodule
